/* verilog/clk_mode_pkg.sv */
package clk_mode_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock rates and derived divider counts
  localparam int CLK_HZ = 125_000_000;
  localparam int FAST_RC_4M_HZ = 4_000_000;
  localparam int FAST_RC_8M_HZ = 8_000_000;
  localparam int FAST_RC_12M_HZ = 12_000_000;
  localparam int SLOW_RC_HZ = 13_000;
  localparam int SLOW_XTAL_HZ = 32_768;
  // Round down: the emulated oscillator never runs slower than its nominal rate
  localparam int FAST_DIV_4M = CLK_HZ / FAST_RC_4M_HZ;
  localparam int FAST_DIV_8M = CLK_HZ / FAST_RC_8M_HZ;
  localparam int FAST_DIV_12M = CLK_HZ / FAST_RC_12M_HZ;
  localparam int SLOW_RC_CYC = CLK_HZ / SLOW_RC_HZ;
  localparam int FAST_DIV_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses) and field positions
  localparam int ADDR_W = 8;
  localparam logic [7:0] CONTROL_REG_ZERO_ADDR = 8'h00;
  localparam logic [7:0] OSC_CFG_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam int CTRL_SPEED_BIT = 0;
  localparam int CTRL_PWR_BIT = 1;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_FREQ_LSB = 2;
  localparam int CFG_SLOW_RC_OFF_BIT = 4;
  localparam logic [31:0] CONTROL_REG_ZERO_RST = 32'h0000_0000;
  localparam logic [31:0] OSC_CFG_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic [1:0] {OSC_INT_RC, OSC_INT_RC_XTAL, OSC_EXT_XTAL, OSC_EXT_RC} osc_cfg_t;
  typedef enum logic [1:0] {FREQ_4M, FREQ_8M, FREQ_12M, FREQ_RSVD} rc_freq_t;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_SLOW, MODE_SLEEP} op_mode_t;
  typedef enum logic [1:0] {PH_RUN, PH_DRAIN, PH_SKIP} mux_phase_t;

endpackage

/* verilog/clk_tick_mux.sv */
`timescale 1ns/1ns
module clk_tick_mux (
  input wire logic clk,
  input wire logic rstn,
  input wire logic fast_tick,
  input wire logic slow_tick,
  input wire logic want_slow,
  output logic tick,
  output logic on_slow
);
  import clk_mode_pkg::*;

  typedef struct packed {
    logic sel;
    clk_mode_pkg::mux_phase_t phase;
    logic tick;
  } mux_state_t;

  mux_state_t st_ff;
  mux_state_t nxt_st;
  logic old_tick;

  assign old_tick = st_ff.sel ? slow_tick : fast_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Hand over only at the old source's edge, then drop the first new edge,
  // so no period shorter than either source ever reaches the core
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    case (st_ff.phase)
      PH_RUN: begin
        nxt_st.tick = old_tick;
        if (want_slow != st_ff.sel) begin
          nxt_st.phase = PH_DRAIN;
        end
      end
      PH_DRAIN: begin
        nxt_st.tick = old_tick;
        if (want_slow == st_ff.sel) begin
          nxt_st.phase = PH_RUN;
        end else if (old_tick) begin
          nxt_st.sel = ~st_ff.sel;
          nxt_st.phase = PH_SKIP;
        end
      end
      PH_SKIP: begin
        // First edge of the new source only restarts its period
        if (old_tick) begin
          nxt_st.phase = PH_RUN;
        end
      end
      default: begin
        nxt_st.phase = PH_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;
  assign on_slow = st_ff.sel;

  property p_skip_quiet;
    @(posedge clk) disable iff (!rstn)
    st_ff.phase == PH_SKIP |=> !tick;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("tick passed while skipping");

  property p_switch_at_edge;
    @(posedge clk) disable iff (!rstn)
    $changed(st_ff.sel) |-> $past(st_ff.phase) == PH_DRAIN && $past(old_tick) ##1 !tick;
  endproperty
  a_switch_at_edge: assert property (p_switch_at_edge) else $error("source switched off an edge");

endmodule

/* verilog/system_clock_mode_control.sv */
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
module system_clock_mode_control #(
  parameter int SLOW_RC_DIV = clk_mode_pkg::SLOW_RC_CYC
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [clk_mode_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic HALT_REQ,
  input wire logic WAKE_REQ,
  input wire logic GPIO5_DO,
  input wire logic GPIO5_OE,
  input wire logic GPIO6_DO,
  input wire logic GPIO6_OE,
  output logic GPIO5_DI,
  output logic GPIO6_DI,
  input wire logic PORT_A_PIN_FIVE_I,
  output logic PORT_A_PIN_FIVE_O,
  output logic PORT_A_PIN_FIVE_OE,
  input wire logic PORT_A_PIN_SIX_I,
  output logic PORT_A_PIN_SIX_O,
  output logic PORT_A_PIN_SIX_OE,
  output logic SYS_TICK,
  output logic WDT_TICK,
  output logic SLOW_XTAL_TICK,
  output logic FAST_EXT_CRYSTAL_OSC_RUN,
  output logic EXT_RESISTOR_CAP_OSC_RUN,
  output logic FAST_INTERNAL_RC_OSC_RUN,
  output logic SLOW_EXT_CRYSTAL_OSC_RUN,
  output logic SLOW_INTERNAL_RC_OSC_RUN,
  output logic SLOW_CRYSTAL_POWER_MODE,
  output logic [1:0] OP_MODE
);
  import clk_mode_pkg::*;

  localparam int SDW = $clog2(SLOW_RC_DIV + 1);

  typedef struct packed {
    logic pin6_s1;
    logic pin6_s2;
    logic pin6_s3;
    logic pin5_s1;
    logic pin5_s2;
    logic sysclk_speed_select;
    logic slow_crystal_power_mode;
    clk_mode_pkg::osc_cfg_t osc_cfg;
    clk_mode_pkg::rc_freq_t rc_freq;
    logic slow_rc_off;
    clk_mode_pkg::op_mode_t mode;
    logic [FAST_DIV_W-1:0] fast_cnt;
    logic [SDW-1:0] slow_cnt;
    logic slow_rc_tick;
    logic pin5_o;
    logic pin5_oe;
    logic pin6_o;
    logic pin6_oe;
    logic gpio5_di;
    logic gpio6_di;
    logic [31:0] prdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic apb_wr;
  logic apb_setup;
  logic xtal_cfg;
  logic pin_edge;
  logic sel_eff;
  logic fast_rc_run;
  logic fast_rc_tick;
  logic fast_tick;
  logic slow_xtal_run;
  logic slow_rc_run;
  logic mux_tick;
  logic mux_on_slow;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == CONTROL_REG_ZERO_ADDR) || (a == OSC_CFG_ADDR) || (a == STATUS_ADDR);
  endfunction

  // Reserved frequency code falls back to the fastest trimmed setting
  function automatic logic [FAST_DIV_W-1:0] fast_div(input rc_freq_t f);
    case (f)
      FREQ_4M: fast_div = FAST_DIV_W'(FAST_DIV_4M - 1);
      FREQ_8M: fast_div = FAST_DIV_W'(FAST_DIV_8M - 1);
      default: fast_div = FAST_DIV_W'(FAST_DIV_12M - 1);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Source decode and oscillator run levels
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_setup = PSEL && !PENABLE;
  assign xtal_cfg = (st_ff.osc_cfg == OSC_INT_RC_XTAL);
  assign pin_edge = st_ff.pin6_s2 && !st_ff.pin6_s3;
  // Speed select only counts in the RC plus crystal setup
  assign sel_eff = st_ff.sysclk_speed_select && xtal_cfg;
  // Fast RC keeps running in Slow until the mux has left it
  assign fast_rc_run = (st_ff.osc_cfg == OSC_INT_RC || xtal_cfg) && st_ff.mode != MODE_SLEEP
                       && !(st_ff.mode == MODE_SLOW && mux_on_slow);
  assign fast_rc_tick = fast_rc_run && st_ff.fast_cnt == '0;
  // External sources clock off the pin edge; both stop in Sleep
  always_comb begin
    case (st_ff.osc_cfg)
      OSC_EXT_XTAL, OSC_EXT_RC: fast_tick = pin_edge && st_ff.mode != MODE_SLEEP;
      default: fast_tick = fast_rc_tick;
    endcase
  end
  // Crystal runs in every mode and with either power setting
  assign slow_xtal_run = xtal_cfg;
  assign slow_rc_run = !st_ff.slow_rc_off;

  ////////////////////////////////////////////////////////////////////////////
  // Glitch-free system clock selection
  clk_tick_mux u_mux (
    .clk(CLK),
    .rstn(RSTN),
    .fast_tick(fast_tick),
    .slow_tick(xtal_cfg ? pin_edge : fast_tick), // No crystal: hand back at a fast edge, never hang
    .want_slow(st_ff.mode == MODE_SLOW),
    .tick(mux_tick),
    .on_slow(mux_on_slow)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    // Pin synchronisers; stage one feeds stage two only
    nxt_st.pin6_s1 = PORT_A_PIN_SIX_I;
    nxt_st.pin6_s2 = st_ff.pin6_s1;
    nxt_st.pin6_s3 = st_ff.pin6_s2;
    nxt_st.pin5_s1 = PORT_A_PIN_FIVE_I;
    nxt_st.pin5_s2 = st_ff.pin5_s1;
    // Register writes land in the access phase
    if (apb_wr && PADDR == CONTROL_REG_ZERO_ADDR) begin
      nxt_st.sysclk_speed_select = PWDATA[CTRL_SPEED_BIT];
      nxt_st.slow_crystal_power_mode = PWDATA[CTRL_PWR_BIT];
    end
    if (apb_wr && PADDR == OSC_CFG_ADDR) begin
      nxt_st.osc_cfg = osc_cfg_t'(PWDATA[CFG_MODE_LSB +: 2]);
      nxt_st.rc_freq = rc_freq_t'(PWDATA[CFG_FREQ_LSB +: 2]);
      nxt_st.slow_rc_off = PWDATA[CFG_SLOW_RC_OFF_BIT];
    end
    // Read data captured in setup so it comes from a flop
    if (apb_setup) begin
      case (PADDR)
        CONTROL_REG_ZERO_ADDR: nxt_st.prdata = {30'h0, st_ff.slow_crystal_power_mode, st_ff.sysclk_speed_select};
        OSC_CFG_ADDR: nxt_st.prdata = {27'h0, st_ff.slow_rc_off, st_ff.rc_freq, st_ff.osc_cfg};
        STATUS_ADDR: nxt_st.prdata = {26'h0, slow_rc_run, slow_xtal_run, fast_rc_run, mux_on_slow, st_ff.mode};
        default: nxt_st.prdata = 32'h0;
      endcase
    end
    // Operating mode; halt wins over a same-cycle speed change
    case (st_ff.mode)
      MODE_NORMAL: begin
        if (HALT_REQ) begin
          nxt_st.mode = MODE_SLEEP;
        end else if (sel_eff) begin
          nxt_st.mode = MODE_SLOW;
        end
      end
      MODE_SLOW: begin
        if (HALT_REQ) begin
          nxt_st.mode = MODE_SLEEP;
        end else if (!sel_eff) begin
          nxt_st.mode = MODE_NORMAL;
        end
      end
      MODE_SLEEP: begin
        if (WAKE_REQ) begin
          nxt_st.mode = sel_eff ? MODE_SLOW : MODE_NORMAL;
        end
      end
      default: begin
        nxt_st.mode = MODE_NORMAL;
      end
    endcase
    // Fast internal RC emulated by a reloading divider
    if (!fast_rc_run || st_ff.fast_cnt == '0) begin
      nxt_st.fast_cnt = fast_div(st_ff.rc_freq);
    end else begin
      nxt_st.fast_cnt = st_ff.fast_cnt - 1'b1;
    end
    // Slow internal RC free-runs for the watchdog
    nxt_st.slow_rc_tick = 1'b0;
    if (!slow_rc_run) begin
      nxt_st.slow_cnt = '0;
    end else if (st_ff.slow_cnt == SDW'(SLOW_RC_DIV - 1)) begin
      nxt_st.slow_cnt = '0;
      nxt_st.slow_rc_tick = 1'b1;
    end else begin
      nxt_st.slow_cnt = st_ff.slow_cnt + 1'b1;
    end
    // Pin sharing: GPIO unless an oscillator claims the pad
    nxt_st.pin5_o = GPIO5_DO;
    nxt_st.pin5_oe = GPIO5_OE;
    nxt_st.pin6_o = GPIO6_DO;
    nxt_st.pin6_oe = GPIO6_OE;
    nxt_st.gpio5_di = st_ff.pin5_s2;
    nxt_st.gpio6_di = st_ff.pin6_s2;
    case (st_ff.osc_cfg)
      OSC_EXT_RC: begin
        nxt_st.pin6_oe = 1'b0;
        nxt_st.pin6_o = 1'b0;
        nxt_st.gpio6_di = 1'b0;
      end
      OSC_EXT_XTAL, OSC_INT_RC_XTAL: begin
        // Pin five drives the inverted pin six as the crystal amplifier
        nxt_st.pin5_o = !st_ff.pin6_s2;
        nxt_st.pin5_oe = 1'b1;
        nxt_st.pin6_o = 1'b0;
        nxt_st.pin6_oe = 1'b0;
        nxt_st.gpio5_di = 1'b0;
        nxt_st.gpio6_di = 1'b0;
      end
      default: begin
        nxt_st.pin5_oe = GPIO5_OE;
        nxt_st.pin6_oe = GPIO6_OE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; all-zero reset clears the power bit for quick start
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign PRDATA = st_ff.prdata;
  assign PREADY = 1'b1; // Zero wait states
  assign PSLVERR = PSEL && PENABLE && !addr_hit(PADDR);
  assign GPIO5_DI = st_ff.gpio5_di;
  assign GPIO6_DI = st_ff.gpio6_di;
  assign PORT_A_PIN_FIVE_O = st_ff.pin5_o;
  assign PORT_A_PIN_FIVE_OE = st_ff.pin5_oe;
  assign PORT_A_PIN_SIX_O = st_ff.pin6_o;
  assign PORT_A_PIN_SIX_OE = st_ff.pin6_oe;
  assign SYS_TICK = mux_tick && st_ff.mode != MODE_SLEEP;
  assign WDT_TICK = st_ff.slow_rc_tick;
  assign SLOW_XTAL_TICK = pin_edge && slow_xtal_run;
  assign FAST_EXT_CRYSTAL_OSC_RUN = st_ff.osc_cfg == OSC_EXT_XTAL && st_ff.mode != MODE_SLEEP;
  assign EXT_RESISTOR_CAP_OSC_RUN = st_ff.osc_cfg == OSC_EXT_RC && st_ff.mode != MODE_SLEEP;
  assign FAST_INTERNAL_RC_OSC_RUN = fast_rc_run;
  assign SLOW_EXT_CRYSTAL_OSC_RUN = slow_xtal_run;
  assign SLOW_INTERNAL_RC_OSC_RUN = slow_rc_run;
  assign SLOW_CRYSTAL_POWER_MODE = st_ff.slow_crystal_power_mode;
  assign OP_MODE = st_ff.mode;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_pwr_write;
    @(posedge CLK) disable iff (!RSTN)
    apb_wr && PADDR == CONTROL_REG_ZERO_ADDR |=> SLOW_CRYSTAL_POWER_MODE == $past(PWDATA[CTRL_PWR_BIT]);
  endproperty
  a_pwr_write: assert property (p_pwr_write) else $error("power bit not written");

  property p_xtal_needs_rc;
    @(posedge CLK) disable iff (!RSTN)
    st_ff.osc_cfg != OSC_INT_RC_XTAL |-> !SLOW_EXT_CRYSTAL_OSC_RUN && !SLOW_XTAL_TICK;
  endproperty
  a_xtal_needs_rc: assert property (p_xtal_needs_rc) else $error("crystal without internal RC");

  property p_sel_ignored;
    @(posedge CLK) disable iff (!RSTN)
    st_ff.osc_cfg != OSC_INT_RC_XTAL && st_ff.mode != MODE_SLOW |=> st_ff.mode != MODE_SLOW;
  endproperty
  a_sel_ignored: assert property (p_sel_ignored) else $error("slow mode outside crystal setup");

  property p_halt_stops;
    @(posedge CLK) disable iff (!RSTN)
    HALT_REQ && st_ff.mode != MODE_SLEEP |=> st_ff.mode == MODE_SLEEP && !SYS_TICK && !FAST_INTERNAL_RC_OSC_RUN;
  endproperty
  a_halt_stops: assert property (p_halt_stops) else $error("halt left fast clock running");

  property p_sleep_xtal;
    @(posedge CLK) disable iff (!RSTN)
    st_ff.mode == MODE_SLEEP && xtal_cfg |-> SLOW_EXT_CRYSTAL_OSC_RUN;
  endproperty
  a_sleep_xtal: assert property (p_sleep_xtal) else $error("crystal stopped in sleep");

  property p_slow_rc_on;
    @(posedge CLK) disable iff (!RSTN)
    !st_ff.slow_rc_off && st_ff.slow_cnt == SDW'(SLOW_RC_DIV - 1) |=> WDT_TICK;
  endproperty
  a_slow_rc_on: assert property (p_slow_rc_on) else $error("slow RC tick missing");

  property p_slow_stops_rc;
    @(posedge CLK) disable iff (!RSTN)
    st_ff.mode == MODE_SLOW && mux_on_slow |-> !FAST_INTERNAL_RC_OSC_RUN;
  endproperty
  a_slow_stops_rc: assert property (p_slow_stops_rc) else $error("fast RC running in slow mode");

  property p_rc_pins;
    @(posedge CLK) disable iff (!RSTN)
    st_ff.osc_cfg == OSC_INT_RC ##1 st_ff.osc_cfg == OSC_INT_RC
      |-> PORT_A_PIN_FIVE_OE == $past(GPIO5_OE) && PORT_A_PIN_SIX_OE == $past(GPIO6_OE);
  endproperty
  a_rc_pins: assert property (p_rc_pins) else $error("pins not free with internal RC");

  property p_erc_pins;
    @(posedge CLK) disable iff (!RSTN)
    st_ff.osc_cfg == OSC_EXT_RC ##1 st_ff.osc_cfg == OSC_EXT_RC
      |-> !PORT_A_PIN_SIX_OE && PORT_A_PIN_FIVE_OE == $past(GPIO5_OE);
  endproperty
  a_erc_pins: assert property (p_erc_pins) else $error("pin use wrong for external RC");

  property p_rc_period;
    @(posedge CLK) disable iff (!RSTN)
    fast_rc_tick && st_ff.rc_freq == FREQ_8M && $stable(st_ff.rc_freq) |=> !fast_rc_tick [*8];
  endproperty
  a_rc_period: assert property (p_rc_period) else $error("fast RC period too short");

endmodule

/* dv/osc_network_model.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module osc_network_model #(
  parameter int HALF_NS = 400
) (
  input wire logic run,
  input wire logic pin_oe,
  input wire logic pin_o,
  output logic pin
);
  logic osc_ff;

  // Resonates only while the pin is handed over; held low otherwise
  // so a stale phase never passes for a live clock
  initial begin
    osc_ff = 1'b0;
    forever begin
      #HALF_NS;
      osc_ff = run ? ~osc_ff : 1'b0;
    end
  end

  // Core drive wins; an undriven pad is pulled high by the resistor
  assign pin = pin_oe ? pin_o : (run ? osc_ff : 1'b1);
endmodule

/* dv/system_clock_mode_control_tb.sv */
`timescale 1ns/1ns
module system_clock_mode_control_tb;
  import clk_mode_pkg::*;
  typedef struct {logic [31:0] cfg; logic [4:0] run; logic oe5; logic oe6; logic di5; int per;} row_t;
  logic CLK, RSTN, PSEL, PENABLE, PWRITE, HALT_REQ, WAKE_REQ, GPIO5_DO, GPIO5_OE, GPIO6_DO, GPIO6_OE;
  logic [ADDR_W-1:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic PREADY, PSLVERR, GPIO5_DI, GPIO6_DI, PORT_A_PIN_FIVE_O, PORT_A_PIN_FIVE_OE, PORT_A_PIN_SIX_O;
  logic PORT_A_PIN_SIX_OE, SYS_TICK, WDT_TICK, SLOW_XTAL_TICK, FAST_EXT_CRYSTAL_OSC_RUN, EXT_RESISTOR_CAP_OSC_RUN;
  logic FAST_INTERNAL_RC_OSC_RUN, SLOW_EXT_CRYSTAL_OSC_RUN, SLOW_INTERNAL_RC_OSC_RUN, SLOW_CRYSTAL_POWER_MODE;
  logic [1:0] OP_MODE;
  logic pad5_ext;
  wire PORT_A_PIN_FIVE_I;
  wire PORT_A_PIN_SIX_I;
  int mismatches, comparisons, g, i, k, mn, last;
  logic [31:0] rd;
  logic er;
  // Config word, run flags {fx,erc,frc,sxt,src}, pad enables, pin five input, tick gap
  row_t rows [7] = '{
    '{32'h00, 5'b00101, 1'b0, 1'b1, 1'b1, 31}, '{32'h04, 5'b00101, 1'b0, 1'b1, 1'b1, 15},
    '{32'h08, 5'b00101, 1'b0, 1'b1, 1'b1, 10}, '{32'h0c, 5'b00101, 1'b0, 1'b1, 1'b1, 10},
    '{32'h11, 5'b00110, 1'b1, 1'b0, 1'b0, 31}, '{32'h02, 5'b10001, 1'b1, 1'b0, 1'b0, 100},
    '{32'h03, 5'b01001, 1'b0, 1'b0, 1'b1, 100}};

  ////////////////////////////////////////////////////////////////////////////////
  // Short watchdog divider keeps the sleep checks brief
  system_clock_mode_control #(.SLOW_RC_DIV(20)) DUT (.*);
  osc_network_model #(.HALF_NS(400)) partner (.run(FAST_EXT_CRYSTAL_OSC_RUN | EXT_RESISTOR_CAP_OSC_RUN |
    SLOW_EXT_CRYSTAL_OSC_RUN), .pin_oe(PORT_A_PIN_SIX_OE), .pin_o(PORT_A_PIN_SIX_O), .pin(PORT_A_PIN_SIX_I));
  // Pin five resolves core drive against the board level
  assign PORT_A_PIN_FIVE_I = PORT_A_PIN_FIVE_OE ? PORT_A_PIN_FIVE_O : pad5_ext;

  // Clock
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task report_and_stop;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Bus transfer; held until ready is seen high at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  function automatic logic tk(input int sel);
    return sel == 0 ? SYS_TICK : (sel == 1 ? WDT_TICK : SLOW_XTAL_TICK);
  endfunction

  // Cycles up to the next tick; a missing tick ends the run
  task wt(input int sel, output int n);
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (tk(sel) !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  // Second call gives a whole period, free of the phase at entry
  task gap(input int sel, output int n);
    wt(sel, n);
    wt(sel, n);
  endtask

  task cnt(input int sel, input int cycles, output int n);
    n = 0;
    repeat (cycles) begin
      @(posedge CLK);
      if (tk(sel) === 1'b1) n++;
    end
  endtask

  // One-cycle core request: halt when h is set, wake otherwise
  task pulse(input logic h);
    @(posedge CLK);
    if (h) HALT_REQ <= 1'b1;
    else WAKE_REQ <= 1'b1;
    @(posedge CLK);
    HALT_REQ <= 1'b0;
    WAKE_REQ <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {RSTN, PSEL, PENABLE, PWRITE, HALT_REQ, WAKE_REQ, GPIO5_DO, GPIO5_OE} = '0;
    {GPIO6_DO, GPIO6_OE, pad5_ext, PADDR, PWDATA} = {3'b111, 40'h0};
    repeat (3) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    chk(SLOW_CRYSTAL_POWER_MODE, 0);
    chk(OP_MODE, MODE_NORMAL);
    apb(1'b0, CONTROL_REG_ZERO_ADDR, 0);
    chk({rd[30:0], er}, {CONTROL_REG_ZERO_RST[30:0], 1'b0});
    // Status after reset: both RC sources run, Normal, mux on the fast leg
    apb(1'b0, STATUS_ADDR, 0);
    chk(rd, 32'h0000_0028);
    apb(1'b0, 8'h0c, 0);
    chk({rd[30:0], er}, 1);
    $display("test reset done");
    // Every oscillator configuration, with its pads and rate
    for (i = 0; i < 7; i++) begin
      apb(1'b1, OSC_CFG_ADDR, rows[i].cfg);
      apb(1'b0, OSC_CFG_ADDR, 0);
      chk(rd, rows[i].cfg);
      repeat (6) @(posedge CLK);
      chk({FAST_EXT_CRYSTAL_OSC_RUN, EXT_RESISTOR_CAP_OSC_RUN, FAST_INTERNAL_RC_OSC_RUN,
           SLOW_EXT_CRYSTAL_OSC_RUN, SLOW_INTERNAL_RC_OSC_RUN}, rows[i].run);
      // GPIO six drives high, so it reads itself back only while it owns the pad
      chk({PORT_A_PIN_FIVE_OE, PORT_A_PIN_SIX_OE, GPIO5_DI, GPIO6_DI, PORT_A_PIN_SIX_O},
          {rows[i].oe5, rows[i].oe6, rows[i].di5, rows[i].oe6, rows[i].oe6});
      gap(0, g);
      chk(g, rows[i].per);
    end
    $display("test table done");
    // Speed select outside the RC plus crystal setup does nothing
    apb(1'b1, CONTROL_REG_ZERO_ADDR, 1);
    repeat (4) @(posedge CLK);
    chk(OP_MODE, MODE_NORMAL);
    gap(0, g);
    chk(g, 100);
    $display("test ignore done");
    // Hand over to the crystal; watch every tick across the switch
    apb(1'b1, OSC_CFG_ADDR, 1);
    repeat (3) @(posedge CLK);
    chk(OP_MODE, MODE_SLOW);
    mn = 9999;
    k = 0;
    last = -1;
    repeat (600) begin
      @(posedge CLK);
      k++;
      if (SYS_TICK === 1'b1) begin
        if (last >= 0 && k - last < mn) mn = k - last;
        last = k;
      end
    end
    chk({last >= 0, mn >= 31}, 3);
    chk({FAST_INTERNAL_RC_OSC_RUN, SLOW_EXT_CRYSTAL_OSC_RUN}, 1);
    gap(0, g);
    chk(g, 100);
    $display("test slow done");
    // Low power once the crystal has long been running
    apb(1'b1, CONTROL_REG_ZERO_ADDR, 3);
    @(posedge CLK);
    chk(SLOW_CRYSTAL_POWER_MODE, 1);
    gap(2, g);
    chk(g, 100);
    // Amplifier pad shows the inverse of the crystal pad, one cycle after the edge
    chk(PORT_A_PIN_FIVE_O, 1);
    @(posedge CLK);
    chk(PORT_A_PIN_FIVE_O, 0);
    chk(OP_MODE, MODE_SLOW);
    // Sleep from slow mode
    pulse(1'b1);
    chk(OP_MODE, MODE_SLEEP);
    cnt(0, 300, g);
    chk({g[29:0], FAST_INTERNAL_RC_OSC_RUN, SLOW_EXT_CRYSTAL_OSC_RUN}, 1);
    gap(2, g);
    chk(g, 100);
    gap(1, g);
    chk(g, 20);
    pulse(1'b0);
    chk(OP_MODE, MODE_SLOW);
    apb(1'b1, CONTROL_REG_ZERO_ADDR, 1);
    @(posedge CLK);
    chk(SLOW_CRYSTAL_POWER_MODE, 0);
    $display("test sleep done");
    // External crystal stops in sleep too, and clocks the core again on wake
    apb(1'b1, CONTROL_REG_ZERO_ADDR, 0);
    apb(1'b1, OSC_CFG_ADDR, 2);
    pulse(1'b1);
    cnt(0, 300, g);
    chk({g[30:0], FAST_EXT_CRYSTAL_OSC_RUN}, 0);
    pulse(1'b0);
    chk({OP_MODE, FAST_EXT_CRYSTAL_OSC_RUN}, 1);
    gap(0, g);
    chk(g, 100);
    $display("test halt done");
    // Reset in mid-run brings back the power-on settings
    apb(1'b1, CONTROL_REG_ZERO_ADDR, 2);
    @(posedge CLK);
    RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    chk({SLOW_CRYSTAL_POWER_MODE, OP_MODE, FAST_INTERNAL_RC_OSC_RUN}, 1);
    apb(1'b0, OSC_CFG_ADDR, 0);
    chk(rd, OSC_CFG_RST);
    gap(0, g);
    chk(g, 31);
    $display("test midrun reset done");
    report_and_stop();
  end
endmodule
